// [include/rec_pkg.sv]
package rec_pkg;

	localparam int unsigned      DATA_W          = 8;
	localparam int unsigned      ADDR_W          = 8;
	localparam int unsigned      VCODE_W         = 7;
	localparam int unsigned      MV_W            = 12;

	// Register offsets
	localparam logic [7:0]       OFS_VCODE       = 8'h00;
	localparam logic [7:0]       OFS_ENABLE      = 8'h01;
	localparam logic [7:0]       OFS_COMMAND     = 8'h02;
	localparam logic [7:0]       OFS_STATUS      = 8'h03;

	// Status register field positions
	localparam int unsigned      ST_MANRST_BIT   = 0;
	localparam int unsigned      ST_WDT_BIT      = 1;
	localparam int unsigned      ST_CHG_BIT      = 2;
	localparam int unsigned      ST_SW_BIT       = 3;
	localparam int unsigned      ST_PUSH_BIT     = 4;
	localparam int unsigned      ST_PGOOD_BIT    = 5;
	localparam int unsigned      ST_STATE_LSB    = 6;

	// Reset values
	localparam logic [6:0]       VCODE_RESET     = 7'h00;
	localparam logic [1:0]       ENABLE_RESET    = 2'h2;

	// Voltage code scale
	localparam logic [11:0]      VOLT_MIN_MV     = 12'h320;
	localparam logic [11:0]      VOLT_STEP_MV    = 12'h019;

	// Enable select encodings
	localparam logic [1:0]       EN_FORCE_OFF    = 2'h0;
	localparam logic [1:0]       EN_FORCE_ON     = 2'h1;
	localparam logic [1:0]       EN_HW_WAKE      = 2'h2;

	// Software power command encodings
	localparam logic [1:0]       CMD_NONE        = 2'h0;
	localparam logic [1:0]       CMD_RESET       = 2'h1;
	localparam logic [1:0]       CMD_POWER_OFF   = 2'h2;
	localparam logic [1:0]       CMD_SHIP_MODE   = 2'h3;

	localparam logic [1:0]       CHG_VALID       = 2'h3;

	// Controller tick and sequence lengths, in system clocks and ticks
	localparam int unsigned      CTRL_DIV        = 100;
	localparam int unsigned      DEBOUNCE_TICKS  = 30;
	localparam int unsigned      UP_TICKS        = 8;
	localparam int unsigned      DOWN_TICKS      = 8;
	localparam int unsigned      CNT_W           = 16;

	typedef enum logic [1:0] {
		REC_OFF  = 2'b00,
		REC_UP   = 2'b01,
		REC_ON   = 2'b10,
		REC_DOWN = 2'b11
	} rec_state_t;

endpackage

// [include/rec_debounce_if.sv]
`timescale 1ns/1ps
interface rec_debounce_if;
	logic tick;
	logic raw_n;
	logic level;
	logic assert_pulse;

	modport ctrl
	(
		output tick,
		output raw_n,
		input  level,
		input  assert_pulse
	);

	modport deb
	(
		input  tick,
		input  raw_n,
		output level,
		output assert_pulse
	);
endinterface

// [hw/rec_debounce.sv]
`timescale 1ns/1ps
module rec_debounce #(
	parameter int unsigned DEBOUNCE_TICKS = rec_pkg::DEBOUNCE_TICKS
) (
	input  wire logic      clk_sys_in,
	input  wire logic      rstn_in,
	rec_debounce_if.deb    dbus
);
	logic [rec_pkg::CNT_W-1:0] count;

	// Level must hold for the full time, counted in controller ticks
	always_ff @(posedge clk_sys_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			count <= '0;
			dbus.level <= 1'b0;
			dbus.assert_pulse <= 1'b0;
		end
		else
		begin
			dbus.assert_pulse <= 1'b0;
			if ((!dbus.raw_n) == dbus.level)
				count <= '0;
			else if (dbus.tick)
			begin
				if (count >= rec_pkg::CNT_W'(DEBOUNCE_TICKS - 1))
				begin
					count <= '0;
					dbus.level <= !dbus.raw_n;
					dbus.assert_pulse <= !dbus.raw_n;
				end
				else
					count <= count + 1'b1;
			end
		end
	end
endmodule

// [hw/rec_regulator_enable_control.sv]
// Behaviour
// - Output target 0.8 V plus 25 mV per code
// - Active discharge on while regulator disabled
// - Enable select 01 powers up regulator
// - Enable select 00 powers down regulator
// - Hardware-wake mode: debounced push sets wake flag
// - Hardware-wake mode: charger becoming valid starts power-up
// - Cold reset completion sets software wake flag only when ENABLE_RESET is hardware-wake
// - Supply or thermal faults force regulator off
// - Power-off command forces regulator off
// - Reset command forces regulator off
// - Ship-mode command forces regulator off
// - Enabled watchdog expiry forces regulator off
// - Manual reset forces regulator off
// - Enable select reset value is parameter
// - Power good held low during sequences
`timescale 1ns/1ps
module rec_regulator_enable_control #(
	parameter logic [1:0]  ENABLE_RESET   = rec_pkg::ENABLE_RESET,
	parameter int unsigned CTRL_DIV       = rec_pkg::CTRL_DIV,
	parameter int unsigned DEBOUNCE_TICKS = rec_pkg::DEBOUNCE_TICKS,
	parameter int unsigned UP_TICKS       = rec_pkg::UP_TICKS,
	parameter int unsigned DOWN_TICKS     = rec_pkg::DOWN_TICKS
) (
	input  wire logic        clk_sys_in,
	input  wire logic        rstn_in,
	input  wire logic [7:0]  addr_in,
	input  wire logic [7:0]  wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic [7:0]       rdata_out,
	input  wire logic        push_wake_input_n_in,
	input  wire logic [1:0]  charger_input_status_in,
	input  wire logic        sys_undervoltage_in,
	input  wire logic        sys_overvoltage_in,
	input  wire logic        over_temperature_in,
	input  wire logic        watchdog_enable_in,
	input  wire logic        watchdog_expire_in,
	input  wire logic        manual_reset_in,
	input  wire logic        reset_actions_done_in,
	input  wire logic        regulator_output_ok_in,
	output logic             regulator_enable_out,
	output logic [6:0]       regulator_voltage_code_out,
	output logic [11:0]      regulator_target_mv_out,
	output logic             active_discharge_out,
	output logic             regulator_power_good_out,
	output logic             regulator_power_good_oe_out
);
	rec_debounce_if dbus ();

	logic [rec_pkg::CNT_W-1:0] div_count;
	logic [rec_pkg::CNT_W-1:0] seq_count;
	logic [6:0]                regulator_voltage_code;
	logic [1:0]                regulator_enable_select;
	logic                      push_wake_flag;
	logic                      software_wake_flag;
	logic                      charger_wake_flag;
	logic                      watchdog_expired_flag;
	logic                      manual_reset_flag;
	logic                      charger_valid_prev;
	logic                      cold_reset_pending;
	rec_pkg::rec_state_t       state;
	rec_pkg::rec_state_t       next_state;
	logic                      fault;
	logic                      cmd_write;
	logic                      kill_req;
	logic                      wake_pending;
	logic                      want_on;
	logic                      charger_rise;

	// Controller clock enable
	always_ff @(posedge clk_sys_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			div_count <= '0;
			dbus.tick <= 1'b0;
		end
		else if (div_count >= rec_pkg::CNT_W'(CTRL_DIV - 1))
		begin
			div_count <= '0;
			dbus.tick <= 1'b1;
		end
		else
		begin
			div_count <= div_count + 1'b1;
			dbus.tick <= 1'b0;
		end
	end

	assign dbus.raw_n = push_wake_input_n_in;

	rec_debounce #(
		.DEBOUNCE_TICKS (DEBOUNCE_TICKS)
	) u_debounce (
		.clk_sys_in (clk_sys_in),
		.rstn_in    (rstn_in),
		.dbus       (dbus)
	);

	assign fault = sys_undervoltage_in || sys_overvoltage_in || over_temperature_in;
	assign cmd_write = wr_in && (addr_in == rec_pkg::OFS_COMMAND);
	// Any nonzero command, enabled expiry or manual reset forces off
	assign kill_req = (cmd_write && (wdata_in[1:0] != rec_pkg::CMD_NONE))
		|| (watchdog_enable_in && watchdog_expire_in)
		|| manual_reset_in;
	assign wake_pending = push_wake_flag || software_wake_flag || charger_wake_flag;
	assign charger_rise = (charger_input_status_in == rec_pkg::CHG_VALID) && !charger_valid_prev;
	assign want_on = !fault && !kill_req
		&& ((regulator_enable_select == rec_pkg::EN_FORCE_ON)
		|| ((regulator_enable_select == rec_pkg::EN_HW_WAKE) && wake_pending));

	// Registers written by software
	always_ff @(posedge clk_sys_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			regulator_voltage_code <= rec_pkg::VCODE_RESET;
			regulator_enable_select <= ENABLE_RESET;
		end
		else if (cmd_write && (wdata_in[1:0] == rec_pkg::CMD_RESET))
			regulator_enable_select <= ENABLE_RESET;
		else if (wr_in && (addr_in == rec_pkg::OFS_VCODE))
			regulator_voltage_code <= wdata_in[6:0];
		else if (wr_in && (addr_in == rec_pkg::OFS_ENABLE))
			regulator_enable_select <= wdata_in[1:0];
	end

	// Wake flags: an event beats a clear in the same cycle
	always_ff @(posedge clk_sys_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			push_wake_flag <= 1'b0;
			charger_wake_flag <= 1'b0;
			software_wake_flag <= 1'b0;
			charger_valid_prev <= 1'b0;
			cold_reset_pending <= 1'b0;
		end
		else
		begin
			charger_valid_prev <= (charger_input_status_in == rec_pkg::CHG_VALID);
			if (cmd_write && (wdata_in[1:0] == rec_pkg::CMD_RESET))
				cold_reset_pending <= 1'b1;
			else if (reset_actions_done_in)
				cold_reset_pending <= 1'b0;
			if (dbus.assert_pulse && (regulator_enable_select == rec_pkg::EN_HW_WAKE))
				push_wake_flag <= 1'b1;
			else if (kill_req || (next_state == rec_pkg::REC_UP))
				push_wake_flag <= 1'b0;
			if (charger_rise && (regulator_enable_select == rec_pkg::EN_HW_WAKE))
				charger_wake_flag <= 1'b1;
			else if (kill_req || (next_state == rec_pkg::REC_UP))
				charger_wake_flag <= 1'b0;
			if (cold_reset_pending && reset_actions_done_in
				&& (ENABLE_RESET == rec_pkg::EN_HW_WAKE))
				software_wake_flag <= 1'b1;
			else if (kill_req || (next_state == rec_pkg::REC_UP))
				software_wake_flag <= 1'b0;
		end
	end

	// Sticky shutdown causes, write one to clear
	always_ff @(posedge clk_sys_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			watchdog_expired_flag <= 1'b0;
			manual_reset_flag <= 1'b0;
		end
		else
		begin
			if (watchdog_enable_in && watchdog_expire_in)
				watchdog_expired_flag <= 1'b1;
			else if (wr_in && (addr_in == rec_pkg::OFS_STATUS) && wdata_in[rec_pkg::ST_WDT_BIT])
				watchdog_expired_flag <= 1'b0;
			if (manual_reset_in)
				manual_reset_flag <= 1'b1;
			else if (wr_in && (addr_in == rec_pkg::OFS_STATUS)
				&& wdata_in[rec_pkg::ST_MANRST_BIT])
				manual_reset_flag <= 1'b0;
		end
	end

	// On/off sequencer
	always_comb
	begin
		next_state = state;
		case (state)
			rec_pkg::REC_OFF:
			begin
				if (want_on)
					next_state = rec_pkg::REC_UP;
			end
			rec_pkg::REC_UP:
			begin
				if (fault || kill_req
					|| (regulator_enable_select == rec_pkg::EN_FORCE_OFF)
					|| (regulator_enable_select == 2'h3))
					next_state = rec_pkg::REC_DOWN;
				else if (dbus.tick && (seq_count >= rec_pkg::CNT_W'(UP_TICKS - 1)))
					next_state = rec_pkg::REC_ON;
			end
			rec_pkg::REC_ON:
			begin
				if (fault || kill_req
					|| (regulator_enable_select == rec_pkg::EN_FORCE_OFF)
					|| (regulator_enable_select == 2'h3))
					next_state = rec_pkg::REC_DOWN;
			end
			rec_pkg::REC_DOWN:
			begin
				if (dbus.tick && (seq_count >= rec_pkg::CNT_W'(DOWN_TICKS - 1)))
					next_state = rec_pkg::REC_OFF;
			end
			default:
				next_state = rec_pkg::REC_OFF;
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			state <= rec_pkg::REC_OFF;
			seq_count <= '0;
		end
		else
		begin
			state <= next_state;
			if (next_state != state)
				seq_count <= '0;
			else if (dbus.tick)
				seq_count <= seq_count + 1'b1;
		end
	end

	// Pin outputs, one cycle behind the sequencer state
	always_ff @(posedge clk_sys_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			regulator_enable_out <= 1'b0;
			active_discharge_out <= 1'b1;
			regulator_power_good_out <= 1'b0;
			regulator_power_good_oe_out <= 1'b1;
			regulator_voltage_code_out <= rec_pkg::VCODE_RESET;
			regulator_target_mv_out <= rec_pkg::VOLT_MIN_MV;
		end
		else
		begin
			regulator_enable_out <= (state == rec_pkg::REC_UP) || (state == rec_pkg::REC_ON);
			active_discharge_out <= (state == rec_pkg::REC_OFF)
				|| (state == rec_pkg::REC_DOWN);
			regulator_power_good_out <= 1'b0;
			// Open drain: release only when on and in regulation
			regulator_power_good_oe_out <= !((state == rec_pkg::REC_ON)
				&& regulator_output_ok_in);
			regulator_voltage_code_out <= regulator_voltage_code;
			regulator_target_mv_out <= rec_pkg::VOLT_MIN_MV
				+ 12'(regulator_voltage_code * rec_pkg::VOLT_STEP_MV);
		end
	end

	// Read port
	always_ff @(posedge clk_sys_in or negedge rstn_in)
	begin
		if (!rstn_in)
			rdata_out <= 8'h00;
		else if (rd_in)
		begin
			case (addr_in)
				rec_pkg::OFS_VCODE:
					rdata_out <= {1'b0, regulator_voltage_code};
				rec_pkg::OFS_ENABLE:
					rdata_out <= {6'h00, regulator_enable_select};
				rec_pkg::OFS_STATUS:
					rdata_out <= {state, !regulator_power_good_oe_out, push_wake_flag,
						software_wake_flag, charger_wake_flag, watchdog_expired_flag,
						manual_reset_flag};
				default:
					rdata_out <= 8'h00;
			endcase
		end
		else
			rdata_out <= 8'h00;
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);

	sequence s_cmd_kill;
		cmd_write && (wdata_in[1:0] != rec_pkg::CMD_NONE);
	endsequence

	sequence s_vcode_write;
		wr_in && (addr_in == rec_pkg::OFS_VCODE) && !cmd_write;
	endsequence

	property p_target_mv;
		s_vcode_write |-> ##2 (regulator_target_mv_out
			== 12'(12'h320 + 12'h019 * {5'h00, $past(wdata_in[6:0], 2)}));
	endproperty
	a_target_mv: assert property (p_target_mv) else $error("target mv wrong");

	property p_discharge;
		(state == rec_pkg::REC_OFF) |=> (active_discharge_out && !regulator_enable_out);
	endproperty
	a_discharge: assert property (p_discharge) else $error("no discharge when off");

	property p_force_on;
		(state == rec_pkg::REC_OFF) && (regulator_enable_select == rec_pkg::EN_FORCE_ON)
			&& !fault && !kill_req |=> (state == rec_pkg::REC_UP) ##1 regulator_enable_out;
	endproperty
	a_force_on: assert property (p_force_on) else $error("force on ignored");

	property p_force_off;
		(state == rec_pkg::REC_ON) && (regulator_enable_select == rec_pkg::EN_FORCE_OFF)
			|=> (state == rec_pkg::REC_DOWN) ##1 !regulator_enable_out;
	endproperty
	a_force_off: assert property (p_force_off) else $error("force off ignored");

	property p_push_wake;
		dbus.assert_pulse && (regulator_enable_select == rec_pkg::EN_HW_WAKE)
			|=> push_wake_flag;
	endproperty
	a_push_wake: assert property (p_push_wake) else $error("push wake lost");

	property p_charger_wake;
		charger_rise && (regulator_enable_select == rec_pkg::EN_HW_WAKE) |=> charger_wake_flag;
	endproperty
	a_charger_wake: assert property (p_charger_wake) else $error("charger wake lost");

	property p_fault_off;
		fault && (state == rec_pkg::REC_ON) |=> (state == rec_pkg::REC_DOWN);
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("fault did not stop");

	property p_cmd_off;
		s_cmd_kill ##0 (state == rec_pkg::REC_ON) |=> (state == rec_pkg::REC_DOWN);
	endproperty
	a_cmd_off: assert property (p_cmd_off) else $error("command did not stop");

	property p_wdt_off;
		watchdog_enable_in && watchdog_expire_in
			&& ((state == rec_pkg::REC_UP) || (state == rec_pkg::REC_ON))
			|=> (state == rec_pkg::REC_DOWN) && watchdog_expired_flag;
	endproperty
	a_wdt_off: assert property (p_wdt_off) else $error("watchdog did not stop");

	property p_mrst_off;
		manual_reset_in && ((state == rec_pkg::REC_UP) || (state == rec_pkg::REC_ON))
			|=> (state == rec_pkg::REC_DOWN) && manual_reset_flag;
	endproperty
	a_mrst_off: assert property (p_mrst_off) else $error("manual reset did not stop");

	property p_pgood_blank;
		(state != rec_pkg::REC_ON) |=> regulator_power_good_oe_out;
	endproperty
	a_pgood_blank: assert property (p_pgood_blank) else $error("power good not blanked");

endmodule

// [tb/rec_host.sv]
`timescale 1ns/1ps
module rec_host (
	input  wire logic       clk_sys_in,
	output logic [7:0]      addr_out,
	output logic [7:0]      wdata_out,
	output logic            wr_out,
	output logic            rd_out,
	input  wire logic [7:0] rdata_in
);
	initial
	begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end

	// Released lines show the inverse, never the last value
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_sys_in);
		wr_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_sys_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
		#1;
		d = rdata_in;
	endtask
endmodule

// [tb/rec_regulator_enable_control_tb_top.sv]
`timescale 1ns/1ps
module rec_regulator_enable_control_tb_top;
	logic        clk;
	logic        rstn;
	logic [7:0]  addr;
	logic [7:0]  wdata;
	logic        wr;
	logic        rd;
	logic [7:0]  rdata;
	logic        push_n;
	logic [1:0]  chg;
	logic [2:0]  flt;
	logic        wd_en;
	logic        wd_exp;
	logic        mrst;
	logic        done;
	logic        ok;
	logic        en;
	logic [6:0]  vcode;
	logic [11:0] mv;
	logic        dis;
	logic        pg;
	logic        pg_oe;
	logic        pg_wire;
	logic [7:0]  d;
	logic [6:0]  c;
	logic [6:0]  q[$];
	int          n_errors;
	int          checks_done;
	int          cyc;

	// Open-drain power good with external pull-up
	assign pg_wire = pg_oe ? pg : 1'b1;

	rec_host u_host (
		.clk_sys_in (clk),
		.addr_out   (addr),
		.wdata_out  (wdata),
		.wr_out     (wr),
		.rd_out     (rd),
		.rdata_in   (rdata)
	);

	rec_regulator_enable_control #(
		.CTRL_DIV       (4),
		.DEBOUNCE_TICKS (3),
		.UP_TICKS       (2),
		.DOWN_TICKS     (2)
	) u_dut (
		.clk_sys_in                  (clk),
		.rstn_in                     (rstn),
		.addr_in                     (addr),
		.wdata_in                    (wdata),
		.wr_in                       (wr),
		.rd_in                       (rd),
		.rdata_out                   (rdata),
		.push_wake_input_n_in        (push_n),
		.charger_input_status_in     (chg),
		.sys_undervoltage_in         (flt[0]),
		.sys_overvoltage_in          (flt[1]),
		.over_temperature_in         (flt[2]),
		.watchdog_enable_in          (wd_en),
		.watchdog_expire_in          (wd_exp),
		.manual_reset_in             (mrst),
		.reset_actions_done_in       (done),
		.regulator_output_ok_in      (ok),
		.regulator_enable_out        (en),
		.regulator_voltage_code_out  (vcode),
		.regulator_target_mv_out     (mv),
		.active_discharge_out        (dis),
		.regulator_power_good_out    (pg),
		.regulator_power_good_oe_out (pg_oe)
	);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic finish_test();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			finish_test();
		end
	end

	task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
		checks_done++;
		if (g !== e)
		begin
			n_errors++;
			$display("unexpected %s expected %0h seen %0h", n, e, g);
		end
	endtask

	task automatic wait_en(input logic v);
		for (int i = 0; i < 80 && en !== v; i++)
			@(posedge clk);
		chk("enable", 12'(v), 12'(en));
	endtask

	task automatic stay_off();
		repeat (60) @(posedge clk);
		chk("enable", 12'h000, 12'(en));
	endtask

	// One-shot kill: 0 watchdog expiry, 1 manual reset
	task automatic kill(input int k);
		@(posedge clk);
		if (k == 0)
			wd_exp <= 1'b1;
		else
			mrst <= 1'b1;
		@(posedge clk);
		wd_exp <= 1'b0;
		mrst <= 1'b0;
	endtask

	initial
	begin
		rstn = 1'b0;
		push_n = 1'b1;
		chg = 2'h0;
		flt = 3'h0;
		wd_en = 1'b0;
		wd_exp = 1'b0;
		mrst = 1'b0;
		done = 1'b0;
		ok = 1'b0;
		void'($urandom(92));
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		#1;
		chk("en_rst", 12'h000, 12'(en));
		chk("dis_rst", 12'h001, 12'(dis));
		chk("pg_rst", 12'h000, 12'(pg_wire));
		chk("mv_rst", 12'h320, mv);
		u_host.rd(rec_pkg::OFS_ENABLE, d);
		chk("sel_rst", 12'(rec_pkg::ENABLE_RESET), 12'(d));
		for (int i = 0; i < 6; i++)
		begin
			c = (i == 0) ? 7'h7f : 7'($urandom_range(126));
			q.push_back(c);
			u_host.wr(rec_pkg::OFS_VCODE, {1'b0, c});
			repeat (2) @(posedge clk);
			#1;
			c = q.pop_front();
			chk("vcode", 12'(c), 12'(vcode));
			chk("mv", 12'(800 + 25 * int'(c)), mv);
		end
		@(posedge clk);
		ok <= 1'b1;
		u_host.wr(rec_pkg::OFS_ENABLE, 8'h01);
		wait_en(1'b1);
		chk("dis_on", 12'h000, 12'(dis));
		chk("pg_up", 12'h000, 12'(pg_wire));
		repeat (20) @(posedge clk);
		u_host.rd(rec_pkg::OFS_STATUS, d);
		chk("state_on", 12'h002, 12'(d[7:6]));
		chk("pg_on", 12'h001, 12'(pg_wire));
		@(posedge clk);
		for (int k = 0; k < 3; k++)
		begin
			flt[k] <= 1'b1;
			wait_en(1'b0);
			chk("dis_flt", 12'h001, 12'(dis));
			flt <= 3'h0;
			wait_en(1'b1);
		end
		u_host.wr(rec_pkg::OFS_COMMAND, {6'h00, rec_pkg::CMD_POWER_OFF});
		wait_en(1'b0);
		wait_en(1'b1);
		u_host.wr(rec_pkg::OFS_COMMAND, {6'h00, rec_pkg::CMD_SHIP_MODE});
		wait_en(1'b0);
		wait_en(1'b1);
		repeat (20) @(posedge clk);
		kill(0);
		repeat (20) @(posedge clk);
		chk("wdt_masked", 12'h001, 12'(en));
		wd_en <= 1'b1;
		kill(0);
		wait_en(1'b0);
		wait_en(1'b1);
		kill(1);
		wait_en(1'b0);
		u_host.rd(rec_pkg::OFS_STATUS, d);
		chk("wdt_flag", 12'h001, 12'(d[rec_pkg::ST_WDT_BIT]));
		chk("mrst_flag", 12'h001, 12'(d[rec_pkg::ST_MANRST_BIT]));
		u_host.wr(rec_pkg::OFS_STATUS, 8'h03);
		u_host.rd(rec_pkg::OFS_STATUS, d);
		chk("flags_clr", 12'h000, 12'(d[1:0]));
		wait_en(1'b1);
		u_host.wr(rec_pkg::OFS_ENABLE, 8'h00);
		wait_en(1'b0);
		chk("dis_off", 12'h001, 12'(dis));
		chk("pg_down", 12'h000, 12'(pg_wire));
		u_host.wr(rec_pkg::OFS_ENABLE, 8'h02);
		stay_off();
		push_n <= 1'b0;
		wait_en(1'b1);
		push_n <= 1'b1;
		repeat (20) @(posedge clk);
		kill(1);
		wait_en(1'b0);
		stay_off();
		chg <= rec_pkg::CHG_VALID;
		wait_en(1'b1);
		flt[0] <= 1'b1;
		wait_en(1'b0);
		flt <= 3'h0;
		stay_off();
		chg <= 2'h0;
		u_host.wr(rec_pkg::OFS_ENABLE, 8'h01);
		wait_en(1'b1);
		u_host.wr(rec_pkg::OFS_COMMAND, {6'h00, rec_pkg::CMD_RESET});
		wait_en(1'b0);
		u_host.rd(rec_pkg::OFS_ENABLE, d);
		chk("sel_reload", 12'(rec_pkg::ENABLE_RESET), 12'(d));
		stay_off();
		@(posedge clk);
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		wait_en(1'b1);
		finish_test();
	end
endmodule
